// ---- shared/flash_host_regs.svh ----
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// Bus widths of the flash word interface
`define FL_ADDR_W        22
`define FL_DATA_W        16

// Clock and strobe timing, in ns as given and derived cycle counts
`define FL_CLK_PERIOD_NS 4
`define FL_T_WP_NS       40
`define FL_T_WPH_NS      20
`define FL_T_ACC_NS      80
`define FL_WP_CYC  ((`FL_T_WP_NS + `FL_CLK_PERIOD_NS - 1) / `FL_CLK_PERIOD_NS)
`define FL_WPH_CYC ((`FL_T_WPH_NS + `FL_CLK_PERIOD_NS - 1) / `FL_CLK_PERIOD_NS)
`define FL_ACC_CYC ((`FL_T_ACC_NS + `FL_CLK_PERIOD_NS - 1) / `FL_CLK_PERIOD_NS)

// Query entry command and address, timeout flag position in status data
`define FL_QUERY_CMD     16'h0098
`define FL_QUERY_ADDR    8'h55
`define FL_TIMEOUT_BIT   5

// Query table size and step counts of the query and autoselect operations
`define FL_QUERY_ENTRIES 22
`define FL_QUERY_STEPS   24
`define FL_AUTOSEL_STEPS 3

`endif

// ---- shared/flash_host_pkg.sv ----
`default_nettype none
`include "flash_host_regs.svh"

package flash_host_pkg;

  typedef enum logic [2:0] {OP_READ, OP_WRITE, OP_RESET, OP_AUTOSEL, OP_QUERY} op_t;

  typedef struct packed {
    op_t                   op;
    logic [`FL_ADDR_W-1:0] addr;
    logic [`FL_DATA_W-1:0] data;
  } cmd_t;

  typedef struct packed {
    logic                  wr;
    logic [`FL_ADDR_W-1:0] addr;
    logic [`FL_DATA_W-1:0] data;
  } cycle_t;

  typedef struct packed {
    logic                  ce_n;
    logic                  we_n;
    logic                  oe_n;
    logic [`FL_ADDR_W-1:0] addr;
    logic [`FL_DATA_W-1:0] dq_out;
    logic                  dq_oe;
  } pins_t;

  typedef enum {CYC_IDLE, CYC_SETUP, CYC_PULSE, CYC_HOLD} cyc_state_t;
  typedef enum {SEQ_IDLE, SEQ_ISSUE, SEQ_WAIT, SEQ_DONE} seq_state_t;

endpackage : flash_host_pkg
`default_nettype wire

// ---- hw/flash_bus_cycle.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_regs.svh"

module flash_bus_cycle #(
  parameter int WP_CYC  = `FL_WP_CYC,
  parameter int WPH_CYC = `FL_WPH_CYC,
  parameter int ACC_CYC = `FL_ACC_CYC
) (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_nrst,
  input  wire logic                   i_start,
  input  wire flash_host_pkg::cycle_t i_cycle,
  input  wire logic [`FL_DATA_W-1:0]  i_dq,
  output flash_host_pkg::pins_t       o_pins,
  output logic [`FL_DATA_W-1:0]       o_rdata,
  output logic                        o_done
);
  import flash_host_pkg::*;

  localparam logic [7:0] WP_LAST  = 8'(WP_CYC - 1);
  localparam logic [7:0] WPH_LAST = 8'(WPH_CYC - 1);
  localparam logic [7:0] ACC_LAST = 8'(ACC_CYC + 1);  // Two extra for the data synchroniser

  cyc_state_t            state, next_state;
  pins_t                 pins, next_pins;
  logic [7:0]            cnt, next_cnt;
  logic                  wr, next_wr;
  logic                  done, next_done;
  logic [`FL_DATA_W-1:0] rdata, next_rdata;
  logic [`FL_DATA_W-1:0] dq_meta, dq_sync;

  //////////////////////////////////////////////////////////////////////////////
  // Strobe sequencing: address set up before the later falling strobe,
  // write data held past the earlier rising strobe
  always_comb begin
    next_state = state;
    next_pins  = pins;
    next_cnt   = cnt;
    next_wr    = wr;
    next_done  = 1'b0;
    next_rdata = rdata;
    unique case (state)
      CYC_IDLE: begin
        if (i_start) begin
          next_pins.addr   = i_cycle.addr;
          next_pins.dq_out = i_cycle.data;
          next_pins.dq_oe  = i_cycle.wr;
          next_pins.ce_n   = 1'b0;
          next_wr          = i_cycle.wr;
          next_state       = CYC_SETUP;
        end
      end
      CYC_SETUP: begin
        if (wr) begin
          next_pins.we_n = 1'b0;  // Later falling edge latches the address
        end else begin
          next_pins.oe_n = 1'b0;
        end
        next_cnt   = 8'h00;
        next_state = CYC_PULSE;
      end
      CYC_PULSE: begin
        next_cnt = cnt + 8'h01;
        if (wr && cnt == WP_LAST) begin
          next_pins.we_n = 1'b1;  // Earlier rising edge latches the data
          next_cnt       = 8'h00;
          next_state     = CYC_HOLD;
        end else if (!wr && cnt == ACC_LAST) begin
          next_rdata     = dq_sync;
          next_pins.oe_n = 1'b1;
          next_pins.ce_n = 1'b1;
          next_cnt       = 8'h00;
          next_state     = CYC_HOLD;
        end
      end
      CYC_HOLD: begin
        next_pins.ce_n = 1'b1;
        next_cnt       = cnt + 8'h01;
        if (cnt == WPH_LAST) begin
          next_pins.dq_oe = 1'b0;
          next_done       = 1'b1;
          next_state      = CYC_IDLE;
        end
      end
    endcase
  end

  // State registers and the two-stage data synchroniser
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state   <= CYC_IDLE;
      pins    <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, default: '0};
      cnt     <= 8'h00;
      wr      <= 1'b0;
      done    <= 1'b0;
      rdata   <= '0;
      dq_meta <= '0;
      dq_sync <= '0;
    end else begin
      state   <= next_state;
      pins    <= next_pins;
      cnt     <= next_cnt;
      wr      <= next_wr;
      done    <= next_done;
      rdata   <= next_rdata;
      dq_meta <= i_dq;
      dq_sync <= dq_meta;
    end
  end

  assign o_pins  = pins;
  assign o_rdata = rdata;
  assign o_done  = done;

  //////////////////////////////////////////////////////////////////////////////
  // Write data is driven and steady when the write strobe rises
  a_wdata_hold: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    $rose(pins.we_n) |-> pins.dq_oe && $stable(pins.dq_out) ##1 pins.dq_oe)
    else $error("write data not held over rising write strobe");

  // Address stays put while chip select is low
  a_addr_steady: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    !pins.ce_n && $past(!pins.ce_n) |-> $stable(pins.addr))
    else $error("address moved during an access");

endmodule : flash_bus_cycle
`default_nettype wire

// ---- hw/flash_query_host.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_regs.svh"

module flash_query_host #(
  parameter logic [`FL_ADDR_W-1:0] UNLOCK1_ADDR = 22'h000001,
  parameter logic [`FL_DATA_W-1:0] UNLOCK1_DATA = 16'h0011,
  parameter logic [`FL_ADDR_W-1:0] UNLOCK2_ADDR = 22'h000002,
  parameter logic [`FL_DATA_W-1:0] UNLOCK2_DATA = 16'h0022,
  parameter logic [`FL_DATA_W-1:0] AUTOSEL_CODE = 16'h0033,
  parameter logic [`FL_DATA_W-1:0] RESET_CODE   = 16'h00FF
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_nrst,
  input  wire flash_host_pkg::cmd_t  i_cmd,
  input  wire logic                  i_cmd_valid,
  output logic                       o_cmd_ready,
  output logic                       o_done,
  output logic [`FL_DATA_W-1:0]      o_rdata,
  output logic                       o_refused,
  output logic                       o_mismatch,
  output logic                       o_timeout,
  input  wire logic [`FL_DATA_W-1:0] i_dq,
  input  wire logic                  i_ready_busy_n,
  output flash_host_pkg::pins_t      o_pins
);
  import flash_host_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Expected extended query table: {address, data}
  function automatic logic [23:0] query_entry(input logic [4:0] k);
    unique case (k)
      5'd0:    query_entry = {8'h40, 16'h0050};
      5'd1:    query_entry = {8'h41, 16'h0052};
      5'd2:    query_entry = {8'h42, 16'h0049};
      5'd3:    query_entry = {8'h43, 16'h0031};
      5'd4:    query_entry = {8'h44, 16'h0033};
      5'd5:    query_entry = {8'h45, 16'h0004};
      5'd6:    query_entry = {8'h46, 16'h0002};
      5'd7:    query_entry = {8'h47, 16'h0001};
      5'd8:    query_entry = {8'h48, 16'h0001};
      5'd9:    query_entry = {8'h49, 16'h0007};
      5'd10:   query_entry = {8'h4A, 16'h0077};
      5'd11:   query_entry = {8'h4B, 16'h0000};
      5'd12:   query_entry = {8'h4C, 16'h0002};
      5'd13:   query_entry = {8'h4D, 16'h0085};
      5'd14:   query_entry = {8'h4E, 16'h0095};
      5'd15:   query_entry = {8'h4F, 16'h0001};
      5'd16:   query_entry = {8'h50, 16'h0001};
      5'd17:   query_entry = {8'h57, 16'h0004};
      5'd18:   query_entry = {8'h58, 16'h0017};
      5'd19:   query_entry = {8'h59, 16'h0030};
      5'd20:   query_entry = {8'h5A, 16'h0030};
      5'd21:   query_entry = {8'h5B, 16'h0017};
      default: query_entry = {8'h00, 16'h0000};
    endcase
  endfunction : query_entry

  // Number of bus cycles each operation takes
  function automatic logic [4:0] step_count(input op_t op);
    unique case (op)
      OP_AUTOSEL: step_count = 5'(`FL_AUTOSEL_STEPS);
      OP_QUERY:   step_count = 5'(`FL_QUERY_STEPS);
      default:    step_count = 5'd1;
    endcase
  endfunction : step_count

  // Bus cycle of step k of an operation; an undefined op code forms a write of its address and data
  function automatic cycle_t make_step(input cmd_t c, input logic [4:0] k);
    logic [23:0] e;
    e         = query_entry(k - 5'd1);
    make_step = '{wr: 1'b1, addr: c.addr, data: c.data};
    unique case (c.op)
      OP_READ:  make_step.wr = 1'b0;
      OP_WRITE: make_step.wr = 1'b1;
      OP_RESET: make_step = '{wr: 1'b1, addr: '0, data: RESET_CODE};
      OP_AUTOSEL: begin
        if (k == 5'd0) begin
          make_step = '{wr: 1'b1, addr: UNLOCK1_ADDR, data: UNLOCK1_DATA};
        end else if (k == 5'd1) begin
          make_step = '{wr: 1'b1, addr: UNLOCK2_ADDR, data: UNLOCK2_DATA};
        end else begin
          make_step = '{wr: 1'b1, addr: c.addr, data: AUTOSEL_CODE};
        end
      end
      OP_QUERY: begin
        if (k == 5'd0) begin
          make_step = '{wr: 1'b1, addr: `FL_ADDR_W'(`FL_QUERY_ADDR), data: `FL_QUERY_CMD};
        end else if (k == 5'(`FL_QUERY_STEPS - 1)) begin
          make_step = '{wr: 1'b1, addr: '0, data: RESET_CODE};
        end else begin
          make_step = '{wr: 1'b0, addr: `FL_ADDR_W'(e[23:16]), data: e[15:0]};
        end
      end
    endcase
  endfunction : make_step

  //////////////////////////////////////////////////////////////////////////////
  seq_state_t            state, next_state;
  cmd_t                  cmd, next_cmd;
  cycle_t                cyc, next_cyc;
  logic [4:0]            idx, next_idx;
  logic                  start, next_start;
  logic                  ready, next_ready;
  logic                  done, next_done;
  logic                  refused, next_refused;
  logic                  mismatch, next_mismatch;
  logic                  timeout, next_timeout;
  logic [`FL_DATA_W-1:0] rdata, next_rdata;
  logic                  rb_meta, rb_sync;
  logic                  busy;
  logic                  cyc_done;
  logic [`FL_DATA_W-1:0] cyc_rdata;
  logic [23:0]           expect_entry;

  assign busy         = !rb_sync;
  assign expect_entry = query_entry(idx - 5'd1);

  // Single bus cycle engine driving the flash pins
  flash_bus_cycle u_cycle (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .i_start   (start),
    .i_cycle   (cyc),
    .i_dq      (i_dq),
    .o_pins    (o_pins),
    .o_rdata   (cyc_rdata),
    .o_done    (cyc_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Operation sequencer
  always_comb begin
    next_state    = state;
    next_cmd      = cmd;
    next_cyc      = cyc;
    next_idx      = idx;
    next_start    = 1'b0;
    next_ready    = ready;
    next_done     = 1'b0;
    next_refused  = refused;
    next_mismatch = mismatch;
    next_timeout  = timeout;
    next_rdata    = rdata;
    unique case (state)
      SEQ_IDLE: begin
        if (i_cmd_valid && ready) begin
          next_ready    = 1'b0;
          next_cmd      = i_cmd;
          next_idx      = 5'd0;
          next_refused  = 1'b0;
          next_mismatch = 1'b0;
          next_timeout  = 1'b0;
          if ((i_cmd.op == OP_AUTOSEL || i_cmd.op == OP_QUERY) && busy) begin
            next_refused = 1'b1;
            next_done    = 1'b1;
            next_state   = SEQ_DONE;
          end else begin
            next_state = SEQ_ISSUE;
          end
        end
      end
      SEQ_ISSUE: begin
        next_cyc   = make_step(cmd, idx);
        next_start = 1'b1;
        next_state = SEQ_WAIT;
      end
      SEQ_WAIT: begin
        if (cyc_done) begin
          if (!cyc.wr) begin
            next_rdata = cyc_rdata;
          end
          if (cmd.op == OP_QUERY && !cyc.wr && cyc_rdata != expect_entry[15:0]) begin
            next_mismatch = 1'b1;
          end
          if (cmd.op == OP_READ && busy && cyc_rdata[`FL_TIMEOUT_BIT]) begin
            next_timeout = 1'b1;
            next_cmd.op  = OP_RESET;
            next_idx     = 5'd0;
            next_state   = SEQ_ISSUE;
          end else if (idx + 5'd1 == step_count(cmd.op)) begin
            next_done  = 1'b1;
            next_state = SEQ_DONE;
          end else begin
            next_idx   = idx + 5'd1;
            next_state = SEQ_ISSUE;
          end
        end
      end
      SEQ_DONE: begin
        next_ready = 1'b1;
        next_state = SEQ_IDLE;
      end
    endcase
  end

  // Sequencer registers and ready/busy synchroniser
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state    <= SEQ_IDLE;
      cmd      <= '0;
      cyc      <= '0;
      idx      <= 5'd0;
      start    <= 1'b0;
      ready    <= 1'b1;
      done     <= 1'b0;
      refused  <= 1'b0;
      mismatch <= 1'b0;
      timeout  <= 1'b0;
      rdata    <= '0;
      rb_meta  <= 1'b1;
      rb_sync  <= 1'b1;
    end else begin
      state    <= next_state;
      cmd      <= next_cmd;
      cyc      <= next_cyc;
      idx      <= next_idx;
      start    <= next_start;
      ready    <= next_ready;
      done     <= next_done;
      refused  <= next_refused;
      mismatch <= next_mismatch;
      timeout  <= next_timeout;
      rdata    <= next_rdata;
      rb_meta  <= i_ready_busy_n;
      rb_sync  <= rb_meta;
    end
  end

  assign o_cmd_ready = ready;
  assign o_done      = done;
  assign o_rdata     = rdata;
  assign o_refused   = refused;
  assign o_mismatch  = mismatch;
  assign o_timeout   = timeout;

  //////////////////////////////////////////////////////////////////////////////
  a_step_bounded: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == SEQ_WAIT |-> idx < step_count(cmd.op))
    else $error("step index beyond operation length");

  a_query_entry: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == SEQ_ISSUE && cmd.op == OP_QUERY && idx == 5'd0 |=> start && cyc.wr
      && cyc.addr == `FL_ADDR_W'(`FL_QUERY_ADDR) && cyc.data == `FL_QUERY_CMD)
    else $error("query entry cycle malformed");

  a_query_exit: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == SEQ_WAIT && cmd.op == OP_QUERY && cyc_done && next_state == SEQ_DONE
      |-> cyc.wr && cyc.data == RESET_CODE)
    else $error("query not left by reset");

  a_autosel_seq: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == SEQ_ISSUE && cmd.op == OP_AUTOSEL && idx == 5'd2 |=> cyc.wr
      && cyc.data == AUTOSEL_CODE && cyc.addr == cmd.addr && $past(idx) == 5'd2)
    else $error("autoselect command cycle malformed");

  a_busy_refuse: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == SEQ_IDLE && i_cmd_valid && ready && busy
      && (i_cmd.op == OP_AUTOSEL || i_cmd.op == OP_QUERY)
      |=> refused && done && !start ##1 ready)
    else $error("busy flash not refused");

  a_timeout_reset: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
    state == SEQ_WAIT && cyc_done && cmd.op == OP_READ && busy && cyc_rdata[`FL_TIMEOUT_BIT]
      |=> timeout ##1 cyc.wr && cyc.data == RESET_CODE && start)
    else $error("timeout flag not followed by reset");

endmodule : flash_query_host
`default_nettype wire

// ---- verif/flash_dev_model.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_regs.svh"

module flash_dev_model #(
  parameter logic [`FL_ADDR_W-1:0] UNLOCK1_ADDR = 22'h000001,
  parameter logic [`FL_DATA_W-1:0] UNLOCK1_DATA = 16'h0011,
  parameter logic [`FL_ADDR_W-1:0] UNLOCK2_ADDR = 22'h000002,
  parameter logic [`FL_DATA_W-1:0] UNLOCK2_DATA = 16'h0022,
  parameter logic [`FL_DATA_W-1:0] AUTOSEL_CODE = 16'h0033,
  parameter logic [`FL_DATA_W-1:0] RESET_CODE   = 16'h00FF,
  parameter logic [`FL_DATA_W-1:0] ID_WORD      = 16'h00C7,  // Arbitrary value
  parameter int                    OP_NS        = 3000
) (
  input  wire flash_host_pkg::pins_t i_pins,
  input  wire logic                  i_op_start,
  input  wire logic                  i_op_fail,
  input  wire logic                  i_bad_query,
  output logic [`FL_DATA_W-1:0]      o_dq,
  output logic                       o_ready_busy_n,
  output logic [`FL_ADDR_W-1:0]      o_last_addr,
  output logic [`FL_DATA_W-1:0]      o_last_data
);
  import flash_host_pkg::*;

  logic [1:0]            mode = 2'h0;
  logic [1:0]            step = 2'h0;
  logic                  busy = 1'b0;
  logic                  fail = 1'b0;
  logic                  wr_act;
  logic                  rd_act;
  logic [`FL_DATA_W-1:0] word;
  logic [`FL_DATA_W-1:0] last = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Query table contents
  function automatic logic [15:0] qword(input logic [7:0] a);
    case (a)
      8'h40:                      qword = 16'h0050;
      8'h41:                      qword = 16'h0052;
      8'h42:                      qword = 16'h0049;
      8'h43:                      qword = 16'h0031;
      8'h44:                      qword = 16'h0033;
      8'h45, 8'h57:               qword = 16'h0004;
      8'h46, 8'h4C:               qword = 16'h0002;
      8'h47, 8'h48, 8'h4F, 8'h50: qword = 16'h0001;
      8'h49:                      qword = 16'h0007;
      8'h4A:                      qword = 16'h0077;
      8'h4D:                      qword = 16'h0085;
      8'h4E:                      qword = 16'h0095;
      8'h58, 8'h5B:               qword = 16'h0017;
      8'h59, 8'h5A:               qword = 16'h0030;
      default:                    qword = 16'h0000;
    endcase
  endfunction : qword

  ////////////////////////////////////////////////////////////////////////////
  // Write cycle is CE low and WE low with OE high
  assign wr_act = !i_pins.ce_n && !i_pins.we_n && i_pins.oe_n;
  assign rd_act = !i_pins.ce_n && !i_pins.oe_n;

  // Address taken at the later falling strobe
  always @(posedge wr_act) begin
    o_last_addr = i_pins.addr;
  end

  // Data taken at the earlier rising strobe, then decoded
  always @(negedge wr_act) begin
    o_last_data = i_pins.dq_out;
    if (o_last_data == RESET_CODE) begin
      if (fail) begin
        busy = 1'b0;
        fail = 1'b0;
      end
      if (!busy) begin
        mode = 2'h0;
      end
      step = 2'h0;
    end else if (!busy) begin
      if (o_last_data == `FL_QUERY_CMD && o_last_addr[7:0] == `FL_QUERY_ADDR) begin
        mode = 2'h1;
      end
      if (step == 2'h0 && o_last_addr == UNLOCK1_ADDR && o_last_data == UNLOCK1_DATA) begin
        step = 2'h1;
      end else if (step == 2'h1 && o_last_addr == UNLOCK2_ADDR
                   && o_last_data == UNLOCK2_DATA) begin
        step = 2'h2;
      end else if (step == 2'h2 && o_last_data == AUTOSEL_CODE) begin
        mode = 2'h2;
        step = 2'h0;
      end else begin
        step = 2'h0;
      end
    end
  end

  // Embedded operation; a failed one waits for the reset command
  always @(posedge i_op_start) begin
    busy = 1'b1;
    fail = i_op_fail;
    #(OP_NS);
    if (!fail) begin
      busy = 1'b0;
      mode = 2'h0;
    end
  end

  assign o_ready_busy_n = !busy;

  // Word shown on a read, by state
  always @* begin
    if (busy) begin
      word = 16'(fail) << `FL_TIMEOUT_BIT;
    end else if (mode == 2'h1) begin
      word = qword(i_pins.addr[7:0]) ^ {15'h0000, i_bad_query && i_pins.addr[7:0] == 8'h4A};
    end else if (mode == 2'h2) begin
      word = ID_WORD;
    end else begin
      word = i_pins.addr[15:0] ^ 16'hA5C3;
    end
  end

  // Released bus shows the inverse of the last word, never a stale copy
  always @(negedge rd_act) begin
    last = word;
  end
  assign o_dq = rd_act ? word : ~last;
endmodule : flash_dev_model
`default_nettype wire

// ---- verif/flash_query_host_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "flash_host_regs.svh"

module flash_query_host_tb_top;
  import flash_host_pkg::*;

  logic        ref_clk;
  logic        nrst;
  cmd_t        cmd;
  logic        cmd_valid;
  logic        cmd_ready;
  logic        done;
  logic [15:0] rdata;
  logic        refused;
  logic        mismatch;
  logic        tmo;
  logic [15:0] dq_dev;
  logic [15:0] dq_bus;
  logic        rbn;
  pins_t       pins;
  logic        op_start;
  logic        op_fail;
  logic        bad_q;
  logic [21:0] last_addr;
  logic [15:0] last_data;
  int          ce_falls        = 0;
  int          errors          = 0;
  int          samples_checked = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Design, device model and data bus
  flash_query_host DUT (.i_ref_clk(ref_clk), .i_nrst(nrst), .i_cmd(cmd),
    .i_cmd_valid(cmd_valid), .o_cmd_ready(cmd_ready), .o_done(done), .o_rdata(rdata),
    .o_refused(refused), .o_mismatch(mismatch), .o_timeout(tmo), .i_dq(dq_bus),
    .i_ready_busy_n(rbn), .o_pins(pins));
  flash_dev_model flash_dev (.i_pins(pins), .i_op_start(op_start), .i_op_fail(op_fail),
    .i_bad_query(bad_q), .o_dq(dq_dev), .o_ready_busy_n(rbn), .o_last_addr(last_addr),
    .o_last_data(last_data));
  assign dq_bus = pins.dq_oe ? pins.dq_out : dq_dev;

  // Chip-select activity counter
  always @(negedge pins.ce_n) begin
    ce_falls++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk16

  task automatic chk1(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic run_op(input op_t op, input logic [21:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(negedge ref_clk);
    cmd = {op, a, d};
    cmd_valid = 1'b1;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    chk1("op_done", 1'b1, done);
  endtask : run_op

  task automatic start_op(input logic f);
    op_fail = f;
    op_start = 1'b1;
    @(negedge ref_clk);
    op_start = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask : start_op

  task automatic finish_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_power_read();
    chk1("ce_n_idle", 1'b1, pins.ce_n);
    chk1("ready_idle", 1'b1, cmd_ready);
    run_op(OP_READ, 22'h012345, 16'h0000);
    chk16("array_word", 16'h8686, rdata);
    chk1("timeout", 1'b0, tmo);
  endtask : t_power_read

  task automatic t_write_latch();
    run_op(OP_WRITE, 22'h2AAAA5, 16'h1234);
    chk16("latched_addr", 16'hAAA5, last_addr[15:0]);
    chk16("latched_data", 16'h1234, last_data);
  endtask : t_write_latch

  task automatic t_query();
    run_op(OP_QUERY, 22'h000000, 16'h0000);
    chk1("mismatch", 1'b0, mismatch);
    chk16("last_query", 16'h0017, rdata);
    chk1("refused", 1'b0, refused);
    run_op(OP_READ, 22'h000040, 16'h0000);
    chk16("array_after_query", 16'hA583, rdata);
    bad_q = 1'b1;
    run_op(OP_QUERY, 22'h000000, 16'h0000);
    chk1("mismatch_bad", 1'b1, mismatch);
    bad_q = 1'b0;
  endtask : t_query

  task automatic t_autosel();
    run_op(OP_AUTOSEL, 22'h100000, 16'h0000);
    chk1("refused", 1'b0, refused);
    run_op(OP_READ, 22'h100000, 16'h0000);
    chk16("id_word", 16'h00C7, rdata);
    run_op(OP_RESET, 22'h100000, 16'h0000);
    run_op(OP_READ, 22'h100000, 16'h0000);
    chk16("array_after_reset", 16'hA5C3, rdata);
  endtask : t_autosel

  task automatic t_busy();
    int n;
    int k;
    k = 0;
    start_op(1'b0);
    n = ce_falls;
    run_op(OP_QUERY, 22'h000000, 16'h0000);
    chk1("query_refused", 1'b1, refused);
    run_op(OP_AUTOSEL, 22'h100000, 16'h0000);
    chk1("autosel_refused", 1'b1, refused);
    chk16("strobes", 16'(n), 16'(ce_falls));
    run_op(OP_RESET, 22'h000000, 16'h0000);
    chk1("still_busy", 1'b0, rbn);
    while (rbn !== 1'b1 && k < 2000) begin
      @(negedge ref_clk);
      k++;
    end
    chk1("op_ended", 1'b1, rbn);
    run_op(OP_READ, 22'h000077, 16'h0000);
    chk16("array_after_op", 16'hA5B4, rdata);
  endtask : t_busy

  task automatic t_timeout();
    start_op(1'b1);
    run_op(OP_READ, 22'h000123, 16'h0000);
    chk1("timeout", 1'b1, tmo);
    chk16("status_word", 16'h0020, rdata);
    chk1("ready_again", 1'b1, rbn);
  endtask : t_timeout

  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  initial begin
    #100000;
    errors++;
    $display("ERROR watchdog expected finish seen hang");
    finish_test();
  end

  initial begin
    nrst = 1'b0;
    cmd = '0;
    cmd_valid = 1'b0;
    op_start = 1'b0;
    op_fail = 1'b0;
    bad_q = 1'b0;
    repeat (6) @(negedge ref_clk);
    nrst = 1'b1;
    t_power_read();
    t_write_latch();
    t_query();
    t_autosel();
    t_busy();
    t_timeout();
    finish_test();
  end
endmodule : flash_query_host_tb_top
`default_nettype wire
